// [rtl/ubg_cfg.svh]
// Purpose: constants for the serial data buffer and baud generator
// Assumes: special-function register space, byte wide, eight-bit addresses
// Notes:   offsets are the printed addresses
// What this block does
// - data register write queues a byte; it is sent only while run bit 6 is set
// - byte waits in holding register before shifter
// - data read returns and pops oldest byte
// - receive FIFO holds at most three bytes
// - pending flag stays set while bytes remain
// - run bit 6 gates the baud generator
// - prescale select divides by 12, 4, 48, 1
// - reload-high gives upper eight reload bits
// - reload-low gives lower eight reload bits
// - control bits 5:2 read zero
// - control bit 7 reads zero
`ifndef UBG_CFG_SVH
`define UBG_CFG_SVH

`define UBG_ADDR_CONTROL     8'hAC
`define UBG_ADDR_RELOAD_LOW  8'hB4
`define UBG_ADDR_RELOAD_HIGH 8'hB5
`define UBG_ADDR_DATA        8'hD3

`define UBG_RUN_BIT          6
`define UBG_PS_LSB           0
`define UBG_CONTROL_MASK     8'h43
`define UBG_RESET_BYTE       8'h00

`define UBG_RX_DEPTH         3
`define UBG_TX_FIFO_DEPTH    8

`define UBG_DIV_SEL0         6'd12
`define UBG_DIV_SEL1         6'd4
`define UBG_DIV_SEL2         6'd48
`define UBG_DIV_SEL3         6'd1

`endif

// [rtl/ubg_pkg.sv]
// Purpose: shared types for the serial data buffer and baud generator
// Assumes: nothing beyond the constants header
// Notes:   register access arrives as one packed request
`default_nettype none
package ubg_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ubg_sfr_req_t;

	typedef enum logic [2:0] {
		UBG_TX_IDLE = 3'b001,
		UBG_TX_LOAD = 3'b010,
		UBG_TX_BUSY = 3'b100
	} ubg_tx_state_t;

endpackage
`default_nettype wire

// [rtl/ubg_fifo.sv]
// Purpose: parameterised valid/ready FIFO for bytes on their way to the shifter
// Assumes: one clock, synchronous active-low reset
// Notes:   read data comes from a register; full and empty are exact
`default_nettype none
module ubg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	// out_data is a register: a pop reloads it with the next entry
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;

	always_ff @(posedge mclk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else if (!out_valid || out_ready)
		begin
			// skid: hold a word in the output register while others wait
			if (cnt_r != '0 && !(out_valid && cnt_r == (AW+1)'(1)))
			begin
				out_valid <= 1'b1;
				out_data  <= out_valid ? mem_r[(rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1]
				                       : mem_r[rp_r];
			end
			else
				out_valid <= 1'b0;
		end
	end

endmodule // ubg_fifo
`default_nettype wire

// [rtl/ubg_core.sv]
// Purpose: data buffers and baud generator of the secondary serial port
// Assumes: registers reached over the special-function register port
// Notes:   frame format and shifter timing live elsewhere
`include "ubg_cfg.svh"
`default_nettype none
module ubg_core
	import ubg_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire ubg_sfr_req_t sfr_req,
	output logic       [7:0]  sfr_rdata,
	input  wire logic         rx_valid,
	input  wire logic  [7:0]  rx_byte,
	output logic              rx_overrun,
	input  wire logic         pend_clear,
	output logic              receive_pending_flag,
	input  wire logic         shifter_free,
	output logic              shifter_load,
	output logic       [7:0]  shifter_byte,
	output logic              tx_room,
	output logic              baud_tick,
	output logic              port_enable
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] control_r;
	logic [7:0] reload_low_r;
	logic [7:0] reload_high_r;
	logic       hit_ctl;
	logic       hit_rll;
	logic       hit_rlh;
	logic       hit_dat;

	assign hit_ctl = sfr_req.addr == `UBG_ADDR_CONTROL;
	assign hit_rll = sfr_req.addr == `UBG_ADDR_RELOAD_LOW;
	assign hit_rlh = sfr_req.addr == `UBG_ADDR_RELOAD_HIGH;
	assign hit_dat = sfr_req.addr == `UBG_ADDR_DATA;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			control_r     <= `UBG_RESET_BYTE;
			reload_low_r  <= `UBG_RESET_BYTE;
			reload_high_r <= `UBG_RESET_BYTE;
		end
		else if (sfr_req.wr)
		begin
			// reserved bits are never stored, so they read zero
			if (hit_ctl)
				control_r <= sfr_req.wdata & `UBG_CONTROL_MASK;
			if (hit_rll)
				reload_low_r <= sfr_req.wdata;
			if (hit_rlh)
				reload_high_r <= sfr_req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	logic       txf_in_ready;
	logic       txf_valid;
	logic [7:0] txf_data;
	logic       take;

	// a write only queues the byte; the holding stage feeds the shifter
	ubg_fifo #(
		.WIDTH (8),
		.DEPTH (`UBG_TX_FIFO_DEPTH)
	) u_txf (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (sfr_req.wr && hit_dat),
		.in_ready  (txf_in_ready),
		.in_data   (sfr_req.wdata),
		.out_valid (txf_valid),
		.out_ready (take),
		.out_data  (txf_data)
	);

	ubg_tx_state_t tx_state_r;

	// one hand-off per free shifter; the LOAD and BUSY states hold off a second take
	assign take = (tx_state_r == UBG_TX_IDLE) && shifter_free && port_enable;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tx_state_r   <= UBG_TX_IDLE;
			shifter_load <= 1'b0;
			shifter_byte <= `UBG_RESET_BYTE;
		end
		else
		begin
			shifter_load <= 1'b0;
			case (tx_state_r)
				UBG_TX_IDLE:
					if (take && txf_valid)
					begin
						shifter_byte <= txf_data;
						shifter_load <= 1'b1;
						tx_state_r   <= UBG_TX_LOAD;
					end
				UBG_TX_LOAD:
					tx_state_r <= UBG_TX_BUSY;
				UBG_TX_BUSY:
					if (shifter_free)
						tx_state_r <= UBG_TX_IDLE;
				default:
					tx_state_r <= UBG_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			tx_room <= 1'b1;
		else
			tx_room <= txf_in_ready;
	end

	// ----------------------------------------------------------------
	// receive FIFO
	// ----------------------------------------------------------------
	logic [7:0] rx_mem_r [`UBG_RX_DEPTH];
	logic [1:0] rx_cnt_r;
	logic       rx_pop;
	logic       rx_push;
	logic [1:0] rx_cnt_nxt;

	assign rx_pop     = sfr_req.rd && hit_dat && (rx_cnt_r != 2'h0);
	assign rx_push    = rx_valid && (rx_cnt_r != 2'(`UBG_RX_DEPTH) || rx_pop);
	assign rx_cnt_nxt = rx_cnt_r + 2'(rx_push) - 2'(rx_pop);

	// shift queue: entry 0 is always the oldest byte
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rx_cnt_r <= 2'h0;
		else
			rx_cnt_r <= rx_cnt_nxt;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `UBG_RX_DEPTH; gi++)
		begin : g_rx
			always_ff @(posedge mclk)
			begin
				if (!rst_n)
					rx_mem_r[gi] <= `UBG_RESET_BYTE;
				else if (rx_push && 2'(gi) == rx_cnt_r - 2'(rx_pop))
					rx_mem_r[gi] <= rx_byte;
				else if (rx_pop && gi < `UBG_RX_DEPTH - 1)
					rx_mem_r[gi] <= rx_mem_r[(gi < `UBG_RX_DEPTH - 1) ? gi + 1 : gi];
			end
		end
	endgenerate

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rx_overrun <= 1'b0;
		else
			rx_overrun <= rx_valid && !rx_push;
	end

	// a clear cannot win while bytes remain; a new byte beats the clear
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			receive_pending_flag <= 1'b0;
		else if (rx_push || (rx_cnt_nxt != 2'h0 && (pend_clear || rx_pop)))
			receive_pending_flag <= 1'b1;
		else if (pend_clear)
			receive_pending_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			sfr_rdata <= `UBG_RESET_BYTE;
		else if (sfr_req.rd)
		begin
			if (hit_ctl)
				sfr_rdata <= control_r;
			else if (hit_rll)
				sfr_rdata <= reload_low_r;
			else if (hit_rlh)
				sfr_rdata <= reload_high_r;
			else if (hit_dat)
				sfr_rdata <= rx_mem_r[0];
			else
				sfr_rdata <= `UBG_RESET_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// baud generator
	// ----------------------------------------------------------------
	logic       run;
	logic [5:0] div_sel;
	logic [5:0] pre_cnt_r;
	logic       pre_tick;
	logic [15:0] baud_cnt_r;

	assign run = control_r[`UBG_RUN_BIT];

	always_comb
	begin
		case (control_r[`UBG_PS_LSB +: 2])
			2'b00:   div_sel = `UBG_DIV_SEL0;
			2'b01:   div_sel = `UBG_DIV_SEL1;
			2'b10:   div_sel = `UBG_DIV_SEL2;
			default: div_sel = `UBG_DIV_SEL3;
		endcase
	end

	assign pre_tick = run && (pre_cnt_r >= div_sel - 6'd1);

	always_ff @(posedge mclk)
	begin
		if (!rst_n || !run)
			pre_cnt_r <= 6'h0;
		else if (pre_tick)
			pre_cnt_r <= 6'h0;
		else
			pre_cnt_r <= pre_cnt_r + 6'd1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			baud_cnt_r <= 16'h0000;
			baud_tick  <= 1'b0;
		end
		else if (!run)
		begin
			// parked on the reload value so a restart gives a full period
			baud_cnt_r <= {reload_high_r, reload_low_r};
			baud_tick  <= 1'b0;
		end
		else
		begin
			baud_tick <= 1'b0;
			if (pre_tick)
			begin
				if (baud_cnt_r == 16'hFFFF)
				begin
					baud_cnt_r <= {reload_high_r, reload_low_r};
					baud_tick  <= 1'b1;
				end
				else
					baud_cnt_r <= baud_cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			port_enable <= 1'b0;
		else
			port_enable <= run;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_rx_read;
		sfr_req.rd && hit_dat && rx_cnt_r != 2'h0;
	endsequence

	rx_depth_limit_a: assert property (@(posedge mclk) disable iff (!rst_n)
		rx_cnt_r <= 2'(`UBG_RX_DEPTH))
		else $error("receive queue above three bytes");

	rx_read_pop_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_rx_read |=> sfr_rdata == $past(rx_mem_r[0]))
		else $error("data read did not return oldest byte");

	rx_read_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_rx_read and !rx_valid) |=> rx_cnt_r == $past(rx_cnt_r) - 2'd1)
		else $error("data read did not remove a byte");

	pend_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		pend_clear && rx_cnt_nxt != 2'h0 |=> receive_pending_flag)
		else $error("pending flag cleared while bytes remain");

	ctl_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(control_r & ~`UBG_CONTROL_MASK) == 8'h00)
		else $error("reserved control bits not zero");

	tx_no_direct_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sfr_req.wr && hit_dat && !txf_valid |=> !shifter_load)
		else $error("write reached shifter without holding stage");

	tx_handoff_a: assert property (@(posedge mclk) disable iff (!rst_n)
		shifter_load |-> $past(shifter_free) ##1 !shifter_load)
		else $error("byte moved to a busy shifter");

	stop_gen_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!run [*2] |-> !baud_tick && pre_cnt_r == 6'h0)
		else $error("generator ran with run bit low");

	presc_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
		run && control_r[1:0] == 2'b01 && pre_tick ##1 (run && control_r[1:0] == 2'b01) [*4]
		|-> pre_tick)
		else $error("divide by four period wrong");

	baud_reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
		run && pre_tick && baud_cnt_r == 16'hFFFF
		|=> baud_tick && baud_cnt_r == $past({reload_high_r, reload_low_r}))
		else $error("overflow did not reload and tick");

	// the count limit alone cannot fail on two bits; this checks the drop itself
	rx_full_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
		rx_valid && rx_cnt_r == 2'(`UBG_RX_DEPTH) && !(sfr_req.rd && hit_dat)
		|=> rx_overrun && rx_cnt_r == 2'(`UBG_RX_DEPTH))
		else $error("byte accepted into a full receive queue");

	pend_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		rx_push |=> receive_pending_flag)
		else $error("pending flag not set by a received byte");

	tx_load_byte_a: assert property (@(posedge mclk) disable iff (!rst_n)
		take && txf_valid |=> shifter_load && shifter_byte == $past(txf_data))
		else $error("held byte not handed to the shifter");

	baud_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		run && pre_tick && baud_cnt_r != 16'hFFFF
		|=> !baud_tick && baud_cnt_r == $past(baud_cnt_r) + 16'h0001)
		else $error("generator did not count up by one");

	port_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> port_enable == $past(run))
		else $error("port enable does not follow run bit");

endmodule // ubg_core
`default_nettype wire

// [verif/ubg_shifter_model.sv]
// Purpose: transmit shifter stand-in that takes bytes and stays busy
// Assumes: load is a one-cycle pulse carrying its byte
// Notes:   stall keeps it busy so the holding queue backs up
`default_nettype none
module ubg_shifter_model (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       stall,
	input  wire logic       shifter_load,
	input  wire logic [7:0] shifter_byte,
	output logic            shifter_free
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// capture log and busy time
	// ----------------------------------------
	logic [7:0] log_q [0:15];
	int         n_seen;
	logic [2:0] busy_r;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			shifter_free <= 1'b1;
			busy_r       <= 3'h0;
			n_seen       <= 0;
		end
		else if (shifter_load)
		begin
			log_q[n_seen[3:0]] <= shifter_byte;
			n_seen             <= n_seen + 1;
			shifter_free       <= 1'b0;
			busy_r             <= 3'h4;
		end
		else if (busy_r != 3'h0)
			busy_r <= busy_r - 3'h1;
		else
			shifter_free <= !stall;
	end
endmodule // ubg_shifter_model
`default_nettype wire

// [verif/uart_buffer_and_baud_generator_bench.sv]
// Purpose: self-checking bench for the data buffers and baud generator
// Assumes: inputs change on the falling edge
// Notes:   read data is sampled two edges after the strobe
`include "ubg_cfg.svh"
`default_nettype none
module uart_buffer_and_baud_generator_bench
	import ubg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	localparam int DIV [4] = '{12, 4, 48, 1};
	logic         mclk = 1'b0;
	logic         rst_n = 1'b0;
	ubg_sfr_req_t sfr_req = '0;
	logic         rx_valid = 1'b0;
	logic   [7:0] rx_byte = 8'h00;
	logic         pend_clear = 1'b0;
	logic         stall = 1'b0;
	logic   [7:0] sfr_rdata;
	logic   [7:0] shifter_byte;
	logic         rx_overrun, receive_pending_flag, shifter_free, shifter_load;
	logic         tx_room, baud_tick, port_enable;
	int           checks = 0;
	int           failures = 0;
	int           ov_seen = 0;

	ubg_core dut (.mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_overrun(rx_overrun),
		.pend_clear(pend_clear), .receive_pending_flag(receive_pending_flag),
		.shifter_free(shifter_free), .shifter_load(shifter_load),
		.shifter_byte(shifter_byte), .tx_room(tx_room), .baud_tick(baud_tick),
		.port_enable(port_enable));
	ubg_shifter_model pm (.mclk(mclk), .rst_n(rst_n), .stall(stall),
		.shifter_load(shifter_load), .shifter_byte(shifter_byte),
		.shifter_free(shifter_free));

	always #2.5 mclk = ~mclk;
	always @(negedge mclk)
		if (rx_overrun === 1'b1)
			ov_seen++;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_req = '{1'b1, 1'b0, a, d};
		@(negedge mclk);
		sfr_req.wr = 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		sfr_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge mclk);
		sfr_req.rd = 1'b0;
		@(negedge mclk);
		chk(nm, e, sfr_rdata);
	endtask
	// a timed-out wait returns 0 so the period compare fails
	task automatic wait_tick(output int n);
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (baud_tick !== 1'b1 && n < 2000);
		if (n == 2000)
			n = 0;
	endtask
	task automatic wait_seen(input int n);
		for (int k = 0; k < 500 && pm.n_seen < n; k++)
			@(negedge mclk);
	endtask
	task automatic pclr();
		@(negedge mclk);
		pend_clear = 1'b1;
		@(negedge mclk);
		pend_clear = 1'b0;
		wait_cyc(2);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		chk("tx_room", 1'b1, tx_room);
		rd_chk("control", `UBG_ADDR_CONTROL, 8'h00);
		rd_chk("reload low", `UBG_ADDR_RELOAD_LOW, 8'h00);
		rd_chk("reload high", `UBG_ADDR_RELOAD_HIGH, 8'h00);
		rd_chk("data", `UBG_ADDR_DATA, 8'h00);
		rd_chk("unmapped", 8'hB6, 8'h00);
		sfr_wr(`UBG_ADDR_CONTROL, 8'hBE);
		rd_chk("control", `UBG_ADDR_CONTROL, 8'h02);
		chk("port_enable", 1'b0, port_enable);
		sfr_wr(`UBG_ADDR_CONTROL, 8'hFF);
		rd_chk("control", `UBG_ADDR_CONTROL, 8'h43);
		chk("port_enable", 1'b1, port_enable);
		sfr_wr(`UBG_ADDR_CONTROL, 8'h00);
		sfr_wr(`UBG_ADDR_RELOAD_HIGH, 8'hA5);
		sfr_wr(`UBG_ADDR_RELOAD_LOW, 8'h5A);
		rd_chk("reload high", `UBG_ADDR_RELOAD_HIGH, 8'hA5);
		rd_chk("reload low", `UBG_ADDR_RELOAD_LOW, 8'h5A);
		$display("test registers done");
	endtask
	// reload FFF0 gives sixteen prescaled steps per tick
	task automatic t_baud();
		int n;
		sfr_wr(`UBG_ADDR_RELOAD_HIGH, 8'hFF);
		sfr_wr(`UBG_ADDR_RELOAD_LOW, 8'hF0);
		for (int s = 0; s < 4; s++)
		begin
			sfr_wr(`UBG_ADDR_CONTROL, 8'h40 | s[7:0]);
			wait_tick(n);
			wait_tick(n);
			chk("baud period", DIV[s] * 16, n[15:0]);
		end
		sfr_wr(`UBG_ADDR_CONTROL, 8'h00);
		wait_cyc(3);
		wait_tick(n);
		chk("stopped ticks", 16'h0000, n[15:0]);
		$display("test baud done");
	endtask
	task automatic t_tx();
		sfr_wr(`UBG_ADDR_DATA, 8'h77);
		wait_cyc(20);
		chk("loads while stopped", 16'h0000, pm.n_seen[15:0]);
		sfr_wr(`UBG_ADDR_CONTROL, 8'h40);
		wait_seen(1);
		chk("first byte", 8'h77, pm.log_q[0]);
		stall = 1'b1;
		for (int k = 0; k < 10; k++)
			sfr_wr(`UBG_ADDR_DATA, 8'h10 + k[7:0]);
		wait_cyc(4);
		chk("tx_room full", 1'b0, tx_room);
		chk("loads while busy", 16'h0001, pm.n_seen[15:0]);
		stall = 1'b0;
		wait_seen(9);
		wait_cyc(20);
		chk("loads", 16'h0009, pm.n_seen[15:0]);
		for (int k = 0; k < 8; k++)
			chk("sent byte", 8'h10 + k[7:0], pm.log_q[k + 1]);
		chk("tx_room free", 1'b1, tx_room);
		$display("test transmit done");
	endtask
	task automatic t_rx();
		for (int k = 0; k < 4; k++)
		begin
			@(negedge mclk);
			rx_valid = 1'b1;
			rx_byte = 8'hA1 + k[7:0];
			@(negedge mclk);
			rx_valid = 1'b0;
			rx_byte = ~rx_byte;
		end
		wait_cyc(2);
		chk("overruns", 16'h0001, ov_seen[15:0]);
		chk("pending", 1'b1, receive_pending_flag);
		rd_chk("oldest", `UBG_ADDR_DATA, 8'hA1);
		pclr();
		chk("pending kept", 1'b1, receive_pending_flag);
		rd_chk("second", `UBG_ADDR_DATA, 8'hA2);
		rd_chk("third", `UBG_ADDR_DATA, 8'hA3);
		pclr();
		chk("pending cleared", 1'b0, receive_pending_flag);
		$display("test receive done");
	endtask
	// ----------------------------------------
	// sequence, watchdog and verdict
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		wait_cyc(2);
		rst_n = 1'b1;
		t_regs();
		t_baud();
		t_tx();
		t_rx();
		end_sim();
	end
	initial
	begin
		#250000;
		failures++;
		end_sim();
	end
endmodule // uart_buffer_and_baud_generator_bench
`default_nettype wire
